// *** pkg/dcp_pkg.sv ***
// Shared constants and types for the control-pin block and its host end.
package dcp_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RESET_MIN_CORE_CYCLES = 5;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_MIN_CORE_CYCLES;
  localparam int unsigned SYNC_DIV = 4;
  localparam int unsigned SCLK_HALF = 4;
  localparam int unsigned SHADOW_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam logic [31:0] SHADOW_RESET = 32'h0000_0000;
  localparam logic [31:0] ACTIVE_RESET = 32'h0000_0000;
  localparam logic [1:0] PROFILE_RESET = 2'h0;
  typedef enum logic [1:0] {
    DCP_IDLE = 2'b00,
    DCP_SHIFT = 2'b01,
    DCP_READ = 2'b10,
    DCP_DONE = 2'b11
  } dcp_xfer_t;
endpackage

// *** pkg/dcp_if.sv ***
// Pin bundle joining the host controller and the control-pin block.
interface dcp_if;
  logic update_strobe;
  logic profile_select_lsb;
  logic profile_select_msb;
  logic hw_reset;
  logic serial_port_abort;
  logic chip_select_n;
  logic serial_clock;
  logic serial_data_host_o;
  logic serial_data_host_oe;
  logic serial_data_dev_o;
  logic serial_data_dev_oe;
  logic serial_data;
  logic serial_read_out;
  logic keying_direction;
  logic sync_clk_out;
  logic sync_in;
  logic oscillator_mode_pin;
  assign serial_data = serial_data_dev_oe ? serial_data_dev_o :
                       serial_data_host_oe ? serial_data_host_o : 1'b0;
  modport device (
    input update_strobe, profile_select_lsb, profile_select_msb, hw_reset,
    input serial_port_abort, chip_select_n, serial_clock, serial_data,
    input keying_direction, sync_in, oscillator_mode_pin,
    output serial_data_dev_o, serial_data_dev_oe, serial_read_out, sync_clk_out
  );
  modport host (
    output update_strobe, profile_select_lsb, profile_select_msb, hw_reset,
    output serial_port_abort, chip_select_n, serial_clock, serial_data_host_o,
    output serial_data_host_oe, keying_direction, oscillator_mode_pin,
    input serial_data, serial_read_out, sync_clk_out
  );
endinterface

// *** verilog/dcp_device.sv ***
// Control-pin logic of the synthesizer: updates, resets, serial port and sync pins.
// Summary of operation
// [RULE1] Update strobe rising edge copies buffer to active.
// [RULE2] Profile pin change also copies buffer to active.
// [RULE3] Profile pins pick one of four, synchronous.
// [RULE4] Hardware reset restores every register to defaults; srst skips osc_enable, pll_in_use, core_clock_ratio, sync_clk_out, sclk_q_reg and shift registers.
// [RULE5] Serial abort high kills transfer at once.
// [RULE6] After abort falls, fresh transfer is accepted.
// [RULE7] Serial port answers only with select low.
// [RULE8] Three-wire mode reads out on dedicated pin.
// [RULE9] Two-wire mode turns data pin around.
// [RULE10] Host supplies the serial clock for bits.
// [RULE11] Keying pin sets ramp direction, synchronous sampling.
// [RULE12] Device emits divided synchronizer clock output.
// [RULE13] Sync input from peer aligns divider phase.
// [RULE14] Oscillator mode pin enables or bypasses oscillator.
// [RULE15] Core clock is reference times multiplier, else reference.
// [RULE16] Host holds hardware reset five core cycles.
// [RULE17] Simultaneous strobe and profile change give one transfer.
module dcp_device #(
  parameter int unsigned SYNC_DIV = dcp_pkg::SYNC_DIV,
  parameter int unsigned MULT_W = 5
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins towards the host.
  dcp_if.device pins,
  // User side.
  input wire logic two_wire_mode,
  input wire logic keying_enable,
  input wire logic [MULT_W-1:0] multiplier,
  input wire logic [7:0] read_data,
  output logic [31:0] active_word,
  output logic [1:0] active_profile,
  output logic update_pulse,
  output logic write_valid,
  output logic [15:0] write_word,
  output logic ramp_up,
  output logic osc_enable,
  output logic pll_in_use,
  output logic [MULT_W:0] core_clock_ratio
);
  localparam int unsigned DIV_W = $clog2(SYNC_DIV);

  if (SYNC_DIV < 2 || MULT_W < 5) begin : g_bad_params
    $error("dcp_device: unsupported parameters");
  end

  logic [DIV_W-1:0] div_reg;
  logic sync_tick;
  logic strobe_q_reg;
  logic [1:0] prof_q_reg;
  logic [31:0] shadow_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] sh_reg;
  logic sclk_q_reg;
  logic [7:0] rd_sh_reg;
  logic rd_drive_reg;
  dcp_pkg::dcp_xfer_t st_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic srst;
  logic do_update;

  assign srst = pins.hw_reset; // [RULE4]
  assign sync_tick = (div_reg == '0);

  // Synchronizer clock divider, realigned by the peer's sync clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (srst || pins.sync_in) begin // [RULE13]
      div_reg <= '0;
    end else if (div_reg == DIV_W'(SYNC_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.sync_clk_out <= 1'b0;
    end else begin
      pins.sync_clk_out <= (div_reg < DIV_W'(SYNC_DIV / 2)); // [RULE12]
    end
  end

  // Update strobe captured every cycle; profile pins captured on the sync clock tick.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q_reg <= 1'b0;
      prof_q_reg <= dcp_pkg::PROFILE_RESET;
    end else if (srst) begin
      strobe_q_reg <= 1'b0;
      prof_q_reg <= dcp_pkg::PROFILE_RESET;
    end else begin
      strobe_q_reg <= pins.update_strobe;
      if (sync_tick) begin // [RULE3]
        prof_q_reg <= {pins.profile_select_msb, pins.profile_select_lsb};
      end
    end
  end

  assign do_update = (pins.update_strobe && !strobe_q_reg) || // [RULE1]
    (sync_tick && ({pins.profile_select_msb, pins.profile_select_lsb} != prof_q_reg)); // [RULE2]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_word <= dcp_pkg::ACTIVE_RESET;
      active_profile <= dcp_pkg::PROFILE_RESET;
      update_pulse <= 1'b0;
    end else if (srst) begin
      active_word <= dcp_pkg::ACTIVE_RESET;
      active_profile <= dcp_pkg::PROFILE_RESET;
      update_pulse <= 1'b0;
    end else begin
      update_pulse <= do_update; // [RULE17]
      if (do_update) begin
        active_word <= shadow_reg;
        if (sync_tick) begin
          active_profile <= {pins.profile_select_msb, pins.profile_select_lsb};
        end else begin
          active_profile <= prof_q_reg;
        end
      end
    end
  end

  // Keying direction and oscillator mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_up <= 1'b0;
      osc_enable <= 1'b0;
      pll_in_use <= 1'b0;
      core_clock_ratio <= '0;
    end else begin
      if (srst || !keying_enable) begin
        ramp_up <= 1'b0;
      end else if (sync_tick) begin
        ramp_up <= pins.keying_direction; // [RULE11]
      end
      osc_enable <= pins.oscillator_mode_pin; // [RULE14]
      pll_in_use <= (multiplier >= MULT_W'(4)) && (multiplier <= MULT_W'(20));
      if ((multiplier >= MULT_W'(4)) && (multiplier <= MULT_W'(20))) begin // [RULE15]
        core_clock_ratio <= {1'b0, multiplier};
      end else begin
        core_clock_ratio <= (MULT_W + 1)'(1);
      end
    end
  end

  // Serial port: 16 bits in per frame; bit 15 high asks for an 8-bit read.
  assign sclk_rise = pins.serial_clock && !sclk_q_reg; // [RULE10]
  assign sclk_fall = !pins.serial_clock && sclk_q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_reg <= 1'b0;
      st_reg <= dcp_pkg::DCP_IDLE;
      bit_cnt_reg <= '0;
      sh_reg <= '0;
      rd_sh_reg <= '0;
      rd_drive_reg <= 1'b0;
      shadow_reg <= dcp_pkg::SHADOW_RESET;
      write_valid <= 1'b0;
      write_word <= '0;
    end else if (srst || pins.serial_port_abort || pins.chip_select_n) begin // [RULE5] [RULE7]
      sclk_q_reg <= pins.serial_clock;
      st_reg <= dcp_pkg::DCP_IDLE; // [RULE6]
      bit_cnt_reg <= '0;
      rd_drive_reg <= 1'b0;
      write_valid <= 1'b0;
      if (srst) begin
        shadow_reg <= dcp_pkg::SHADOW_RESET;
        write_word <= '0;
      end
    end else begin
      sclk_q_reg <= pins.serial_clock;
      write_valid <= 1'b0;
      case (st_reg)
        dcp_pkg::DCP_IDLE, dcp_pkg::DCP_SHIFT: begin
          st_reg <= dcp_pkg::DCP_SHIFT;
          if (sclk_rise) begin
            sh_reg <= {sh_reg[14:0], pins.serial_data};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == 5'd15) begin
              bit_cnt_reg <= '0;
              if (sh_reg[14]) begin
                st_reg <= dcp_pkg::DCP_READ;
                rd_sh_reg <= read_data;
              end else begin
                st_reg <= dcp_pkg::DCP_DONE;
                write_valid <= 1'b1;
                write_word <= {sh_reg[14:0], pins.serial_data};
                shadow_reg <= {shadow_reg[15:0], sh_reg[14:0], pins.serial_data};
              end
            end
          end
        end
        dcp_pkg::DCP_READ: begin
          // The data pin is taken over only after the host has let go of it.
          if (sclk_fall) begin
            rd_drive_reg <= 1'b1; // [RULE9]
          end
          if (sclk_fall && bit_cnt_reg != 5'd0) begin
            rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
          end
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == 5'd7) begin
              st_reg <= dcp_pkg::DCP_DONE;
            end
          end
        end
        default: begin
          st_reg <= dcp_pkg::DCP_DONE;
        end
      endcase
    end
  end

  // Read data drives the dedicated pin or, in two-wire mode, the data pin.
  always_comb begin
    pins.serial_read_out = 1'b0;
    pins.serial_data_dev_o = 1'b0;
    pins.serial_data_dev_oe = 1'b0;
    if (st_reg == dcp_pkg::DCP_READ && rd_drive_reg && !pins.chip_select_n) begin
      if (two_wire_mode) begin
        pins.serial_data_dev_o = rd_sh_reg[7]; // [RULE9]
        pins.serial_data_dev_oe = 1'b1;
      end else begin
        pins.serial_read_out = rd_sh_reg[7]; // [RULE8]
      end
    end
  end
endmodule

// *** verilog/dcp_host.sv ***
// Host end: drives the control pins and runs serial frames into the device.
module dcp_host #(
  parameter int unsigned SCLK_HALF = dcp_pkg::SCLK_HALF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pins towards the device.
  dcp_if.host pins,
  // User side.
  input wire logic two_wire_mode,
  input wire logic start,
  input wire logic [15:0] frame,
  input wire logic update_req,
  input wire logic [1:0] profile,
  input wire logic keying_level,
  input wire logic reset_req,
  input wire logic abort_req,
  input wire logic osc_mode,
  output logic busy,
  output logic [7:0] read_byte,
  output logic done
);
  localparam int unsigned HALF_W = $clog2(SCLK_HALF + 1);

  if (SCLK_HALF < 2) begin : g_bad_params
    $error("dcp_host: SCLK_HALF too small");
  end

  logic [HALF_W-1:0] half_reg;
  logic [4:0] bits_reg;
  logic [15:0] sh_reg;
  logic rd_reg;
  logic [2:0] rst_cnt_reg;
  logic sync_q_reg;

  // Hardware reset held for the least pulse width.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_reg <= '0;
      pins.hw_reset <= 1'b0;
    end else if (reset_req) begin
      rst_cnt_reg <= 3'(dcp_pkg::RESET_HOLD_CYCLES); // [RULE16]
      pins.hw_reset <= 1'b1;
    end else if (rst_cnt_reg != '0) begin
      rst_cnt_reg <= rst_cnt_reg - 1'b1;
      pins.hw_reset <= (rst_cnt_reg != 3'd1);
    end else begin
      pins.hw_reset <= 1'b0;
    end
  end

  // Profile and keying pins change just after the synchronizer clock rises.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q_reg <= 1'b0;
      pins.profile_select_lsb <= 1'b0;
      pins.profile_select_msb <= 1'b0;
      pins.keying_direction <= 1'b0;
      pins.update_strobe <= 1'b0;
      pins.oscillator_mode_pin <= 1'b0;
      pins.serial_port_abort <= 1'b0;
    end else begin
      sync_q_reg <= pins.sync_clk_out;
      pins.oscillator_mode_pin <= osc_mode;
      pins.serial_port_abort <= abort_req;
      pins.update_strobe <= update_req;
      if (pins.sync_clk_out && !sync_q_reg) begin // [RULE3] [RULE11]
        {pins.profile_select_msb, pins.profile_select_lsb} <= profile;
        pins.keying_direction <= keying_level;
      end
    end
  end

  // Serial frame engine: select low, clock out bits, read 8 when bit 15 set.
  assign busy = !pins.chip_select_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.chip_select_n <= 1'b1;
      pins.serial_clock <= 1'b0;
      pins.serial_data_host_o <= 1'b0;
      pins.serial_data_host_oe <= 1'b0;
      half_reg <= '0;
      bits_reg <= '0;
      sh_reg <= '0;
      rd_reg <= 1'b0;
      read_byte <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort_req) begin
        pins.chip_select_n <= 1'b1;
        pins.serial_clock <= 1'b0;
        pins.serial_data_host_oe <= 1'b0;
      end else if (pins.chip_select_n) begin
        if (start) begin
          pins.chip_select_n <= 1'b0; // [RULE7]
          sh_reg <= {frame[14:0], 1'b0};
          pins.serial_data_host_o <= frame[15];
          pins.serial_data_host_oe <= 1'b1;
          rd_reg <= frame[15];
          bits_reg <= '0;
          half_reg <= '0;
        end
      end else if (half_reg != HALF_W'(SCLK_HALF - 1)) begin
        half_reg <= half_reg + 1'b1;
      end else begin
        half_reg <= '0;
        pins.serial_clock <= !pins.serial_clock; // [RULE10]
        if (pins.serial_clock) begin
          bits_reg <= bits_reg + 1'b1;
          if (bits_reg == 5'd15) begin
            pins.serial_data_host_oe <= 1'b0; // [RULE9]
            if (!rd_reg) begin
              pins.chip_select_n <= 1'b1;
              done <= 1'b1;
            end
          end else if (bits_reg == 5'd23) begin
            pins.chip_select_n <= 1'b1;
            done <= 1'b1;
          end else if (bits_reg < 5'd15) begin
            pins.serial_data_host_o <= sh_reg[15];
            sh_reg <= {sh_reg[14:0], 1'b0};
          end
        end else if (bits_reg >= 5'd16) begin
          read_byte <= {read_byte[6:0],
                        two_wire_mode ? pins.serial_data : pins.serial_read_out};
        end
      end
    end
  end
endmodule

// *** tb/dcp_pins_chk.sv ***
// Checker watching the pins between the host end and the control-pin block.
module dcp_pins_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched pins.
  input wire logic hw_reset,
  input wire logic serial_port_abort,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_host_oe,
  input wire logic serial_data_dev_oe,
  input wire logic sync_clk_out,
  input wire logic sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_sync_period;
    disable iff (!rst_n || sync_in || hw_reset)
    $rose(sync_clk_out) |-> sync_clk_out [*2] ##1 !sync_clk_out [*2] ##1 sync_clk_out;
  endproperty
  a_sync_period: assert property (p_sync_period)
    else $error("sync clock period wrong");

  property p_reset_hold;
    $rose(hw_reset) |-> hw_reset [*5];
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("hardware reset too short");

  property p_idle_quiet;
    chip_select_n && $past(chip_select_n) |-> !serial_data_dev_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("data driven without select");

  property p_abort_quiet;
    serial_port_abort && $past(serial_port_abort) |-> !serial_data_dev_oe;
  endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("data driven during abort");

  property p_after_abort;
    $fell(serial_port_abort) |-> !serial_data_dev_oe [*2];
  endproperty
  a_after_abort: assert property (p_after_abort)
    else $error("old transfer resumed after abort");

  property p_one_driver;
    !(serial_data_dev_oe && serial_data_host_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive data");

  property p_sclk_high;
    disable iff (!rst_n || serial_port_abort)
    $rose(serial_clock) |-> serial_clock [*4] ##1 (!serial_clock || chip_select_n);
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high phase wrong");

  property p_sclk_low;
    disable iff (!rst_n || serial_port_abort)
    $fell(serial_clock) && !chip_select_n |-> !serial_clock [*4];
  endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("serial clock low phase wrong");

  c_read: cover property ($rose(serial_data_dev_oe));
  c_abort: cover property ($rose(serial_port_abort));
  c_reset: cover property ($rose(hw_reset));
endmodule

// *** tb/dds_control_pin_interface_bench.sv ***
// Testbench joining the host end and the control-pin block.
module dds_control_pin_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, tw, ken, start, upd, kl, rreq, areq, osc, pll, upls, wv, rup, osce, busy, done;
  logic [4:0] mult;
  logic [7:0] rd, rbyte;
  logic [15:0] frame, wword, last_w;
  logic [1:0] prof, aprof;
  logic [31:0] aword;
  logic [5:0] ratio;
  logic oe_seen;
  int n_errors, compares, n_upd, n_wr, n_done;
  dcp_if pins ();
  dcp_device i_dcp_device (.clk(clk), .rst_n(rst_n), .pins(pins.device), .two_wire_mode(tw),
    .keying_enable(ken), .multiplier(mult), .read_data(rd), .active_word(aword),
    .active_profile(aprof), .update_pulse(upls), .write_valid(wv), .write_word(wword),
    .ramp_up(rup), .osc_enable(osce), .pll_in_use(pll), .core_clock_ratio(ratio));
  dcp_host i_dcp_host (.clk(clk), .rst_n(rst_n), .pins(pins.host), .two_wire_mode(tw),
    .start(start), .frame(frame), .update_req(upd), .profile(prof), .keying_level(kl),
    .reset_req(rreq), .abort_req(areq), .osc_mode(osc), .busy(busy), .read_byte(rbyte),
    .done(done));
  dcp_pins_chk i_dcp_pins_chk (.clk(clk), .rst_n(rst_n), .hw_reset(pins.hw_reset),
    .serial_port_abort(pins.serial_port_abort), .chip_select_n(pins.chip_select_n),
    .serial_clock(pins.serial_clock), .serial_data_host_oe(pins.serial_data_host_oe),
    .serial_data_dev_oe(pins.serial_data_dev_oe), .sync_clk_out(pins.sync_clk_out),
    .sync_in(pins.sync_in));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (upls === 1'b1) n_upd++;
    if (wv === 1'b1) begin
      n_wr++;
      last_w = wword;
    end
    if (pins.serial_data_dev_oe === 1'b1) oe_seen = 1'b1;
    if (done === 1'b1) n_done++;
  end

  task results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task wait_idle;
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      cyc(1);
      i++;
    end
    check(i < 400, "host stuck busy");
    cyc(2);
  endtask

  task send(input logic [15:0] f);
    int n0;
    n0 = n_done;
    frame = f;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(1);
    wait_idle();
    check(n_done == n0 + 1, "frame done pulse");
  endtask

  task t_misc;
    int ms[4];
    bit in;
    ms = '{3, 4, 20, 21};
    osc = 1'b1;
    ken = 1'b1;
    kl = 1'b1;
    cyc(12);
    check(osce === 1'b1, "oscillator not enabled");
    check(rup === 1'b1, "ramp not up");
    osc = 1'b0;
    ken = 1'b0;
    cyc(12);
    check(osce === 1'b0, "oscillator not bypassed");
    check(rup === 1'b0, "keying not held low");
    kl = 1'b0;
    foreach (ms[k]) begin
      mult = 5'(ms[k]);
      in = ms[k] >= 4 && ms[k] <= 20;
      cyc(4);
      check(pll === in, "multiplier use");
      check(ratio === (in ? 6'(ms[k]) : 6'h01), "clock ratio");
    end
  endtask

  task t_write_update;
    int n0;
    send(16'h1234);
    send(16'h5678);
    check(n_wr == 2 && last_w === 16'h5678, "serial writes");
    check(aword === 32'h0000_0000, "active changed before update");
    n0 = n_upd;
    upd = 1'b1;
    cyc(3);
    upd = 1'b0;
    cyc(3);
    check(n_upd == n0 + 1, "update count");
    check(aword === 32'h1234_5678, "active word after update");
  endtask

  task t_profile;
    int n0;
    for (int p = 0; p < 5; p++) begin
      prof = (p == 4) ? 2'h0 : 2'(p ^ 1);
      n0 = n_upd;
      cyc(16);
      check(n_upd == n0 + 1, "profile change update count");
      check(aprof === prof, "active profile");
    end
  endtask

  task t_both;
    int n0;
    int i;
    n0 = n_upd;
    prof = 2'h2;
    i = 0;
    while ({pins.profile_select_msb, pins.profile_select_lsb} !== prof && i < 20) begin
      cyc(1);
      i++;
    end
    cyc(1);
    upd = 1'b1;
    cyc(3);
    upd = 1'b0;
    cyc(8);
    check(i < 20 && n_upd == n0 + 1, "joint update count");
    check(aprof === 2'h2, "joint update profile");
    prof = 2'h0;
    cyc(16);
  endtask

  task t_read(input logic two, input logic [7:0] v);
    tw = two;
    rd = v;
    cyc(2);
    oe_seen = 1'b0;
    send(16'h8000);
    check(rbyte === v, "read byte");
    check(oe_seen === two, "data pin direction");
  endtask

  task t_abort;
    int n0;
    n0 = n_wr;
    frame = 16'h0abc;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(30);
    areq = 1'b1;
    cyc(3);
    areq = 1'b0;
    wait_idle();
    check(n_wr == n0, "aborted frame wrote");
    send(16'h0011);
    check(n_wr == n0 + 1 && last_w === 16'h0011, "write after abort");
  endtask

  task t_sync;
    pins.sync_in = 1'b1;
    cyc(6);
    check(pins.sync_clk_out === 1'b1, "sync input phase");
    pins.sync_in = 1'b0;
    cyc(4);
  endtask

  task t_hwreset;
    rreq = 1'b1;
    cyc(1);
    rreq = 1'b0;
    cyc(12);
    check(aword === dcp_pkg::ACTIVE_RESET, "active word reset");
    check(aprof === dcp_pkg::PROFILE_RESET, "profile reset");
    upd = 1'b1;
    cyc(3);
    upd = 1'b0;
    cyc(3);
    check(aword === dcp_pkg::SHADOW_RESET, "buffer reset");
  endtask

  initial begin
    {clk, rst_n, tw, ken, start, upd, kl, rreq, areq, osc, oe_seen} = '0;
    {mult, rd, frame, prof, last_w} = '0;
    pins.sync_in = 1'b0;
    n_errors = 0;
    compares = 0;
    n_upd = 0;
    n_wr = 0;
    n_done = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    cyc(2);
    t_misc();
    t_write_update();
    t_profile();
    t_both();
    t_read(1'b0, 8'ha5);
    t_read(1'b1, 8'h3c);
    t_abort();
    t_sync();
    t_hwreset();
    results();
  end

  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
